// ### vpg_pkg.sv
// Constants for the planar graphics datapath
package vpg_pkg;
	localparam logic [15:0] IO_INDEX_ADDR = 16'h03CE;
	localparam logic [15:0] IO_DATA_ADDR = 16'h03CF;
	localparam logic [3:0] IDX_SET_RESET = 4'h0;
	localparam logic [3:0] IDX_SR_ENABLE = 4'h1;
	localparam logic [3:0] IDX_COMPARE = 4'h2;
	localparam logic [3:0] IDX_LOGIC_ROT = 4'h3;
	localparam logic [3:0] IDX_READ_PLANE = 4'h4;
	localparam int INDEX_W = 4;
	localparam int OP_LSB = 3;
	localparam int ROT_W = 3;
	localparam int PLANES = 4;
	localparam logic [7:0] MASK_ALL = 8'hFF;
	localparam logic [3:0] RST_NIB = 4'h0;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	typedef enum logic [1:0] {
		WM_DIRECT = 2'b00,
		WM_LATCH = 2'b01,
		WM_EXPAND = 2'b10,
		WM_COLOUR = 2'b11
	} vpg_wmode_e;
	typedef enum logic [1:0] {
		OP_PASS = 2'b00,
		OP_AND = 2'b01,
		OP_OR = 2'b10,
		OP_XOR = 2'b11
	} vpg_op_e;
endpackage

// ### vpg_datapath.sv
// Graphics controller write/read datapath for four 8-bit planes
`timescale 1ns/1ns
`default_nettype none
module vpg_datapath
	import vpg_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic [15:0] io_addr_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic [7:0] io_wdata_i,
	output logic [7:0] io_rdata_o,
	input wire logic [1:0] write_mode_i,
	input wire logic read_mode_i,
	input wire logic odd_even_i,
	input wire logic [7:0] bit_mask_i,
	input wire logic mem_wr_i,
	input wire logic mem_rd_i,
	input wire logic mem_a0_i,
	input wire logic [7:0] mem_wdata_i,
	input wire logic [31:0] plane_rdata_i,
	output logic [31:0] plane_wdata_o,
	output logic plane_we_o,
	output logic [7:0] mem_rdata_o,
	output logic mem_rvalid_o
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [3:0] idx;
		logic [3:0] sr;
		logic [3:0] sre;
		logic [3:0] cc;
		logic [1:0] op;
		logic [2:0] rot;
		logic [1:0] rps;
		logic [31:0] latch;
		logic [7:0] io_rdata;
		logic [7:0] mem_rdata;
		logic rvalid;
		logic [31:0] pwdata;
		logic pwe;
	} vpg_st_s;

	vpg_st_s st_ff;
	vpg_st_s nxt_st;

	function automatic logic io_hit(input logic [15:0] a, input logic [15:0] b);
		io_hit = (a == b);
	endfunction

	function automatic logic [7:0] rotr(input logic [7:0] d, input logic [2:0] n);
		logic [15:0] w;
		w = {d, d} >> n;
		rotr = w[7:0];
	endfunction

	// ****************************************************************
	// Write shaping per plane
	// ****************************************************************
	vpg_wmode_e wmode;
	logic [7:0] rot_data;
	logic [7:0] wmask;
	logic [31:0] new_planes;
	logic [7:0] cmp_bits;
	logic [1:0] rd_sel;
	logic [7:0] sel_byte;

	assign wmode = vpg_wmode_e'(write_mode_i);
	assign rot_data = rotr(mem_wdata_i, st_ff.rot);
	assign wmask = (wmode == WM_COLOUR) ? (rot_data & bit_mask_i) : bit_mask_i;

	genvar gp;
	generate
		for (gp = 0; gp < PLANES; gp = gp + 1) begin : g_plane
			logic [7:0] fill;
			logic [7:0] lat;
			logic [7:0] alu;
			assign lat = st_ff.latch[8*gp +: 8];
			assign fill = (wmode == WM_EXPAND) ? {8{mem_wdata_i[gp]}} :
				(wmode == WM_COLOUR || st_ff.sre[gp]) ? {8{st_ff.sr[gp]}} :
				rot_data;
			assign alu = (st_ff.op == OP_AND) ? (fill & lat) :
				(st_ff.op == OP_OR) ? (fill | lat) :
				(st_ff.op == OP_XOR) ? (fill ^ lat) : fill;
			assign new_planes[8*gp +: 8] = (wmode == WM_LATCH) ? lat :
				((alu & wmask) | (lat & ~wmask));
		end
		for (gp = 0; gp < 8; gp = gp + 1) begin : g_cmp
			assign cmp_bits[gp] = &(~({plane_rdata_i[24+gp], plane_rdata_i[16+gp],
				plane_rdata_i[8+gp], plane_rdata_i[gp]} ^ st_ff.cc));
		end
	endgenerate

	// odd/even replaces select bit 0 with address bit 0
	assign rd_sel = {st_ff.rps[1], odd_even_i ? mem_a0_i : st_ff.rps[0]};
	assign sel_byte = plane_rdata_i[8*rd_sel +: 8];

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		nxt_st = st_ff;
		nxt_st.pwe = 1'b0;
		nxt_st.rvalid = 1'b0;
		if (io_wr_i && io_hit(io_addr_i, IO_INDEX_ADDR)) begin
			nxt_st.idx = io_wdata_i[INDEX_W-1:0];
		end else if (io_wr_i && io_hit(io_addr_i, IO_DATA_ADDR)) begin
			if (st_ff.idx == IDX_SET_RESET) begin
				nxt_st.sr = io_wdata_i[3:0];
			end else if (st_ff.idx == IDX_SR_ENABLE) begin
				nxt_st.sre = io_wdata_i[3:0];
			end else if (st_ff.idx == IDX_COMPARE) begin
				nxt_st.cc = io_wdata_i[3:0];
			end else if (st_ff.idx == IDX_LOGIC_ROT) begin
				nxt_st.op = io_wdata_i[OP_LSB +: 2];
				nxt_st.rot = io_wdata_i[ROT_W-1:0];
			end else if (st_ff.idx == IDX_READ_PLANE) begin
				nxt_st.rps = io_wdata_i[1:0];
			end
		end
		if (io_rd_i) begin
			nxt_st.io_rdata = 8'h00;
			if (io_hit(io_addr_i, IO_INDEX_ADDR)) begin
				nxt_st.io_rdata = {4'h0, st_ff.idx};
			end else if (io_hit(io_addr_i, IO_DATA_ADDR)) begin
				if (st_ff.idx == IDX_SET_RESET) begin
					nxt_st.io_rdata = {4'h0, st_ff.sr};
				end else if (st_ff.idx == IDX_SR_ENABLE) begin
					nxt_st.io_rdata = {4'h0, st_ff.sre};
				end else if (st_ff.idx == IDX_COMPARE) begin
					nxt_st.io_rdata = {4'h0, st_ff.cc};
				end else if (st_ff.idx == IDX_LOGIC_ROT) begin
					nxt_st.io_rdata = {3'h0, st_ff.op, st_ff.rot};
				end else if (st_ff.idx == IDX_READ_PLANE) begin
					nxt_st.io_rdata = {6'h00, st_ff.rps};
				end
			end
		end
		if (mem_wr_i) begin
			nxt_st.pwdata = new_planes;
			nxt_st.pwe = 1'b1;
		end
		if (mem_rd_i) begin
			nxt_st.latch = plane_rdata_i;
			nxt_st.mem_rdata = read_mode_i ? cmp_bits : sel_byte;
			nxt_st.rvalid = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_ff <= '{idx: RST_NIB, sr: RST_NIB, sre: RST_NIB, cc: RST_NIB,
				op: 2'h0, rot: 3'h0, rps: 2'h0, latch: RST_WORD,
				io_rdata: 8'h00, mem_rdata: 8'h00, rvalid: 1'b0,
				pwdata: RST_WORD, pwe: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign io_rdata_o = st_ff.io_rdata;
	assign plane_wdata_o = st_ff.pwdata;
	assign plane_we_o = st_ff.pwe;
	assign mem_rdata_o = st_ff.mem_rdata;
	assign mem_rvalid_o = st_ff.rvalid;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);

	a_index_readback: assert property (
		io_rd_i && io_addr_i == IO_INDEX_ADDR |=> io_rdata_o[7:4] == 4'h0)
		else $error("index upper bits not zero");
	a_latch_write: assert property (
		mem_wr_i && write_mode_i == WM_LATCH && !mem_rd_i
		|=> plane_we_o && plane_wdata_o == $past(st_ff.latch))
		else $error("mode 1 write not from latches");
	a_expand_fill: assert property (
		mem_wr_i && write_mode_i == WM_EXPAND && st_ff.op == OP_PASS &&
		bit_mask_i == MASK_ALL |=> plane_wdata_o[31:24] == {8{$past(mem_wdata_i[3])}})
		else $error("mode 2 plane 3 fill wrong");
	a_colour_fill: assert property (
		mem_wr_i && write_mode_i == WM_COLOUR && st_ff.op == OP_PASS &&
		st_ff.rot == 3'h0 && mem_wdata_i == MASK_ALL && bit_mask_i == MASK_ALL
		|=> plane_wdata_o[7:0] == {8{$past(st_ff.sr[0])}})
		else $error("mode 3 colour fill wrong");
	a_sr_enable: assert property (
		mem_wr_i && write_mode_i == WM_DIRECT && st_ff.sre[1] &&
		st_ff.op == OP_PASS && bit_mask_i == MASK_ALL
		|=> plane_wdata_o[15:8] == {8{$past(st_ff.sr[1])}})
		else $error("set/reset enable ignored");
	a_mask_keep: assert property (
		mem_wr_i && bit_mask_i == 8'h00 && !mem_rd_i
		|=> plane_wdata_o == $past(st_ff.latch))
		else $error("masked bits not preserved");
	a_xor_rotate: assert property (
		mem_wr_i && write_mode_i == WM_DIRECT && !st_ff.sre[0] &&
		st_ff.op == OP_XOR && st_ff.rot == 3'h1 && bit_mask_i == MASK_ALL
		|=> plane_wdata_o[7:0] ==
		$past({mem_wdata_i[0], mem_wdata_i[7:1]} ^ st_ff.latch[7:0]))
		else $error("xor or rotate wrong");
	a_read_latch: assert property (
		mem_rd_i |=> mem_rvalid_o && st_ff.latch == $past(plane_rdata_i))
		else $error("latches not loaded on read");
	a_plane_read: assert property (
		mem_rd_i && !read_mode_i |=> mem_rdata_o == $past(sel_byte))
		else $error("plane read wrong");
	a_compare_read: assert property (
		mem_rd_i && read_mode_i && plane_rdata_i == RST_WORD &&
		st_ff.cc == RST_NIB |=> mem_rdata_o == MASK_ALL)
		else $error("compare read wrong");

	c_mode3_write: cover property (mem_wr_i && write_mode_i == WM_COLOUR);
	c_compare_read: cover property (mem_rd_i && read_mode_i);
	c_odd_even_read: cover property (mem_rd_i && odd_even_i && mem_a0_i);
	c_read_then_w1: cover property (mem_rd_i ##1 mem_wr_i && write_mode_i == WM_LATCH);

endmodule
`default_nettype wire

// ### vpg_plane_mem.sv
// Plane memory model at the far side of the datapath
`timescale 1ns/1ns
`default_nettype none
module vpg_plane_mem (
	input wire logic sys_clk_i,
	input wire logic we_i,
	input wire logic [31:0] wdata_i,
	input wire logic load_i,
	input wire logic [31:0] init_i,
	output logic [31:0] rdata_o
);
	always_ff @(posedge sys_clk_i) begin
		if (load_i) begin
			rdata_o <= init_i;
		end else if (we_i) begin
			rdata_o <= wdata_i;
		end
	end
endmodule
`default_nettype wire

// ### tb.sv
// Self-checking bench for the planar graphics datapath
`timescale 1ns/1ns
`default_nettype none
module tb;
	import vpg_pkg::*;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic iow = 1'h0, ior = 1'h0, mw = 1'h0, mr = 1'h0, rm = 1'h0;
	logic oe = 1'h0, a0 = 1'h0, ld = 1'h0, we, rv;
	logic [1:0] wm = 2'h0;
	logic [7:0] wd = 8'h00, mk = 8'h00, iod = 8'h00, iord, mrd;
	logic [15:0] ioa = 16'h0000;
	logic [31:0] pr, pw, init = 32'h0000_0000, lat;
	logic [3:0] sr, en;
	logic [1:0] op;
	logic [2:0] rot;
	int n_errors = 0;
	int n_compared = 0;
	always #5 clk = ~clk;
	vpg_datapath vpg_datapath_inst (.sys_clk_i(clk), .arst_n_i(rst_n),
		.io_addr_i(ioa), .io_wr_i(iow), .io_rd_i(ior), .io_wdata_i(iod),
		.io_rdata_o(iord), .write_mode_i(wm), .read_mode_i(rm),
		.odd_even_i(oe), .bit_mask_i(mk), .mem_wr_i(mw), .mem_rd_i(mr),
		.mem_a0_i(a0), .mem_wdata_i(wd), .plane_rdata_i(pr),
		.plane_wdata_o(pw), .plane_we_o(we), .mem_rdata_o(mrd),
		.mem_rvalid_o(rv));
	vpg_plane_mem vpg_plane_mem_inst (.sys_clk_i(clk), .we_i(we),
		.wdata_i(pw), .load_i(ld), .init_i(init), .rdata_o(pr));
	task automatic stop_test();
		$display("compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, g, e);
		end
	endtask
	// Expected plane bytes of one host write
	function automatic logic [31:0] model(input logic [1:0] m,
		input logic [7:0] d, input logic [7:0] k);
		logic [7:0] r, s, o, g, l;
		r = 8'(({d, d} >> rot));
		g = (m == 2'h3) ? (r & k) : k;
		for (int p = 0; p < 4; p++) begin
			l = lat[8*p+:8];
			s = (m == 2'h2) ? {8{d[p]}} : r;
			s = (m == 2'h3 || (m == 2'h0 && en[p])) ? {8{sr[p]}} : s;
			o = (op == 2'h1) ? (s & l) : (op == 2'h2) ? (s | l) : s;
			o = (op == 2'h3) ? (s ^ l) : o;
			model[8*p+:8] = (m == 2'h1) ? l : ((o & g) | (l & ~g));
		end
	endfunction
	task automatic io(input logic w, input logic [15:0] a,
		input logic [7:0] d);
		@(posedge clk);
		iow <= w;
		ior <= !w;
		ioa <= a;
		iod <= d;
		@(posedge clk);
		iow <= 1'h0;
		ior <= 1'h0;
		#1;
	endtask
	task automatic prog(input logic [3:0] s, input logic [3:0] e,
		input logic [4:0] o, input logic [1:0] p);
		logic [7:0] v[5];
		v = '{{4'h0, s}, {4'h0, e}, 8'h0A, {3'h0, o}, {6'h00, p}};
		sr = s;
		en = e;
		op = o[4:3];
		rot = o[2:0];
		for (int i = 0; i < 5; i++) begin
			io(1'h1, IO_INDEX_ADDR, 8'(i));
			io(1'h1, IO_DATA_ADDR, v[i]);
			io(1'h0, IO_DATA_ADDR, 8'h00);
			chk(32'(iord), 32'(v[i]));
		end
	endtask
	task automatic rd(input logic m, input logic o, input logic a,
		input logic [31:0] w, input logic [7:0] e);
		@(posedge clk);
		ld <= 1'h1;
		init <= w;
		@(posedge clk);
		ld <= 1'h0;
		mr <= 1'h1;
		rm <= m;
		oe <= o;
		a0 <= a;
		@(posedge clk);
		mr <= 1'h0;
		#1;
		chk(32'(rv), 32'h0000_0001);
		chk(32'(mrd), 32'(e));
		lat = w;
	endtask
	task automatic wr(input logic [1:0] m, input logic [7:0] d,
		input logic [7:0] k);
		@(posedge clk);
		mw <= 1'h1;
		wm <= m;
		wd <= d;
		mk <= k;
		@(posedge clk);
		mw <= 1'h0;
		#1;
		chk(32'(we), 32'h0000_0001);
		chk(pw, model(m, d, k));
	endtask
	task automatic t_regs();
		prog(4'h5, 4'h3, 5'h19, 2'h2);
		io(1'h1, IO_INDEX_ADDR, 8'hF4);
		io(1'h0, IO_INDEX_ADDR, 8'h00);
		chk(32'(iord), 32'h0000_0004);
		io(1'h1, IO_INDEX_ADDR, 8'h05);
		io(1'h0, IO_DATA_ADDR, 8'h00);
		chk(32'(iord), 32'h0000_0000);
		$display("test regs done");
	endtask
	task automatic t_read();
		prog(4'h5, 4'h3, 5'h19, 2'h3);
		rd(1'h0, 1'h0, 1'h0, 32'h4433_2211, 8'h44);
		rd(1'h0, 1'h1, 1'h0, 32'h4433_2211, 8'h33);
		rd(1'h1, 1'h1, 1'h1, 32'hFF0F_F300, 8'hF0);
		$display("test read done");
	endtask
	task automatic t_write();
		rd(1'h0, 1'h0, 1'h0, 32'h1234_5678, 8'h12);
		wr(2'h1, 8'hAA, 8'h00);
		wr(2'h2, 8'h05, 8'hFF);
		for (int o = 0; o < 4; o++) begin
			prog(4'h5, 4'h3, {2'(o), 3'h1}, 2'h3);
			wr(2'h0, 8'h81, 8'hF0);
		end
		prog(4'h9, 4'h0, 5'h02, 2'h3);
		wr(2'h3, 8'h3C, 8'h7E);
		$display("test write done");
	endtask
	task automatic t_shape();
		// zero compare colour against blank planes
		io(1'h1, IO_INDEX_ADDR, 8'h02);
		io(1'h1, IO_DATA_ADDR, 8'h00);
		rd(1'h1, 1'h0, 1'h0, 32'h0000_0000, 8'hFF);
		prog(4'h9, 4'h0, 5'h00, 2'h3);
		wr(2'h2, 8'h05, 8'hFF);
		wr(2'h3, 8'hFF, 8'hFF);
		prog(4'h6, 4'h2, 5'h00, 2'h3);
		wr(2'h0, 8'h81, 8'hFF);
		prog(4'h6, 4'h2, 5'h19, 2'h3);
		wr(2'h0, 8'h81, 8'hFF);
		$display("test shape done");
	endtask
	initial begin
		#100000;
		n_errors++;
		stop_test();
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'h1;
		t_regs();
		t_read();
		t_write();
		t_shape();
		stop_test();
	end
endmodule
`default_nettype wire
